// ==== rtl/cfitg_pkg.sv ====
// Constants for the query timing and geometry table and its sector locator.
// Operation
// - Address 1Fh reads 06h, typical byte program timeout exponent.
// - Address 20h reads 0Ah for both page buffer options.
// - Address 21h reads 08h for 4/64 KB sectors, 0Ah for 256 KB.
// - Address 22h reads 0Fh, typical chip erase timeout exponent.
// - Addresses 23h to 26h read 02h, 02h, 03h, 03h.
// - Address 1Bh reads 27h and 1Ch reads 36h, supply limits.
// - Addresses 1Dh and 1Eh read 00h, no programming supply.
// - Address 27h reads 18h, device size exponent.
// - Addresses 28h and 29h read 02h and 01h, interface code 0102h.
// - Hybrid: 2Ah reads 08h and 2Bh reads 00h.
// - Hybrid: 2Ch reads 02h, two erase block regions.
// - Hybrid: bytes 2Dh to 30h read 0Fh, 00h, 10h, 00h.
// - Hybrid: bytes 31h to 34h read FEh, 00h, 00h, 01h.
// - Hybrid part delivers its sixteen small sectors at the bottom.
// - Top-select bit moves small sectors to top; table bytes unchanged.
// - Uniform part describes one region of 64 sectors of 256 KB.
package cfitg_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ARR_W = 24;

  localparam logic [7:0] A_VCC_MIN = 8'h1b;
  localparam logic [7:0] A_VCC_MAX = 8'h1c;
  localparam logic [7:0] A_VPP_MIN = 8'h1d;
  localparam logic [7:0] A_VPP_MAX = 8'h1e;
  localparam logic [7:0] A_TYP_BYTE = 8'h1f;
  localparam logic [7:0] A_TYP_PAGE = 8'h20;
  localparam logic [7:0] A_TYP_SECT = 8'h21;
  localparam logic [7:0] A_TYP_CHIP = 8'h22;
  localparam logic [7:0] A_MAX_BYTE = 8'h23;
  localparam logic [7:0] A_MAX_PAGE = 8'h24;
  localparam logic [7:0] A_MAX_SECT = 8'h25;
  localparam logic [7:0] A_MAX_CHIP = 8'h26;
  localparam logic [7:0] A_DEV_SIZE = 8'h27;
  localparam logic [7:0] A_IF_LO = 8'h28;
  localparam logic [7:0] A_IF_HI = 8'h29;
  localparam logic [7:0] A_WBUF_LO = 8'h2a;
  localparam logic [7:0] A_WBUF_HI = 8'h2b;
  localparam logic [7:0] A_NREGION = 8'h2c;
  localparam logic [7:0] A_REG1_0 = 8'h2d;
  localparam logic [7:0] A_REG1_1 = 8'h2e;
  localparam logic [7:0] A_REG1_2 = 8'h2f;
  localparam logic [7:0] A_REG1_3 = 8'h30;
  localparam logic [7:0] A_REG2_0 = 8'h31;
  localparam logic [7:0] A_REG2_1 = 8'h32;
  localparam logic [7:0] A_REG2_2 = 8'h33;
  localparam logic [7:0] A_REG2_3 = 8'h34;
  localparam logic [7:0] A_FIRST = 8'h1b;
  localparam logic [7:0] A_LAST = 8'h3f;

  localparam logic [7:0] D_VCC_MIN = 8'h27;
  localparam logic [7:0] D_VCC_MAX = 8'h36;
  localparam logic [7:0] D_NO_VPP = 8'h00;
  localparam logic [7:0] D_TYP_BYTE = 8'h06;
  localparam logic [7:0] D_TYP_PAGE_256 = 8'h0a;
  localparam logic [7:0] D_TYP_PAGE_512 = 8'h0a;
  localparam logic [7:0] D_TYP_SECT_SMALL = 8'h08;
  localparam logic [7:0] D_TYP_SECT_BIG = 8'h0a;
  localparam logic [7:0] D_TYP_CHIP = 8'h0f;
  localparam logic [7:0] D_MAX_PROG = 8'h02;
  localparam logic [7:0] D_MAX_ERASE = 8'h03;
  localparam logic [7:0] D_DEV_SIZE = 8'h18;
  localparam logic [7:0] D_IF_LO = 8'h02;
  localparam logic [7:0] D_IF_HI = 8'h01;
  localparam logic [7:0] D_WBUF_HYB = 8'h08;
  localparam logic [7:0] D_WBUF_UNI = 8'h09;
  localparam logic [7:0] D_ZERO = 8'h00;
  localparam logic [7:0] D_NREG_HYB = 8'h02;
  localparam logic [7:0] D_NREG_UNI = 8'h01;
  localparam logic [7:0] D_R1_CNT_HYB = 8'h0f;
  localparam logic [7:0] D_R1_SZ_HYB = 8'h10;
  localparam logic [7:0] D_R1_CNT_UNI = 8'h3f;
  localparam logic [7:0] D_R1_SZ_UNI = 8'h04;
  localparam logic [7:0] D_R2_CNT_HYB = 8'hfe;
  localparam logic [7:0] D_R2_SZ_HYB = 8'h01;
  localparam logic [7:0] D_RFU = 8'hff;

  // Sector sizes of the locator, coded as log2 of the byte count.
  localparam logic [4:0] SZ_SMALL = 5'h0c;
  localparam logic [4:0] SZ_MID = 5'h10;
  localparam logic [4:0] SZ_BIG = 5'h12;
  localparam logic [3:0] SMALL_CNT = 4'hf;
  localparam logic [7:0] TOP_BLOCK = 8'hff;
  localparam logic [8:0] MID_BASE_IDX = 9'h010;
  localparam logic [8:0] MID_TOP_OFS = 9'h001;
endpackage : cfitg_pkg

// ==== rtl/cfitg_rom.sv ====
// Combinational byte table for the supply, timeout and geometry part of the query data.
`timescale 1ns/1ps
module cfitg_rom
  import cfitg_pkg::*;
(
  input wire logic [ADDR_W-1:0] addr,
  input wire logic uniform,
  input wire logic page512,
  output logic [DATA_W-1:0] data
);
  always_comb begin
    data = D_RFU;
    case (addr)
      A_VCC_MIN: data = D_VCC_MIN;
      A_VCC_MAX: data = D_VCC_MAX;
      A_VPP_MIN, A_VPP_MAX: data = D_NO_VPP;
      A_TYP_BYTE: data = D_TYP_BYTE;
      A_TYP_PAGE: data = page512 ? D_TYP_PAGE_512 : D_TYP_PAGE_256;
      A_TYP_SECT: data = uniform ? D_TYP_SECT_BIG : D_TYP_SECT_SMALL;
      A_TYP_CHIP: data = D_TYP_CHIP;
      A_MAX_BYTE, A_MAX_PAGE: data = D_MAX_PROG;
      A_MAX_SECT, A_MAX_CHIP: data = D_MAX_ERASE;
      A_DEV_SIZE: data = D_DEV_SIZE;
      A_IF_LO: data = D_IF_LO;
      A_IF_HI: data = D_IF_HI;
      A_WBUF_LO: data = uniform ? D_WBUF_UNI : D_WBUF_HYB;
      A_WBUF_HI: data = D_ZERO;
      A_NREGION: data = uniform ? D_NREG_UNI : D_NREG_HYB;
      A_REG1_0: data = uniform ? D_R1_CNT_UNI : D_R1_CNT_HYB;
      A_REG1_1: data = D_ZERO;
      A_REG1_2: data = uniform ? D_ZERO : D_R1_SZ_HYB;
      A_REG1_3: data = uniform ? D_R1_SZ_UNI : D_ZERO;
      // The uniform part has a single region, so region two reads as reserved there.
      A_REG2_0: data = uniform ? D_RFU : D_R2_CNT_HYB;
      A_REG2_1, A_REG2_2: data = uniform ? D_RFU : D_ZERO;
      A_REG2_3: data = uniform ? D_RFU : D_R2_SZ_HYB;
      default: data = D_RFU;
    endcase
  end
endmodule : cfitg_rom

// ==== rtl/cfitg_top.sv ====
// Query table read port, write refusal and array sector locator of the flash device.
`timescale 1ns/1ps
module cfitg_top
  import cfitg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic opt_uniform,
  input wire logic opt_page512,
  input wire logic small_sector_top_select,
  input wire logic rd_req,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic wr_req,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic loc_req,
  input wire logic [ARR_W-1:0] loc_addr,
  output logic ready_r,
  output logic rd_valid_r,
  output logic [DATA_W-1:0] rd_data_r,
  output logic rd_in_range_r,
  output logic wr_refused_r,
  output logic [ADDR_W-1:0] wr_refused_addr_r,
  output logic loc_valid_r,
  output logic loc_small_r,
  output logic [8:0] loc_index_r,
  output logic [4:0] loc_size_r,
  output logic [ARR_W-1:0] loc_base_r,
  output logic small_top_r
);
  // Two states suffice: one edge to catch the straps, then normal running.
  typedef enum logic [1:0] {
    CFITG_ST_CAPTURE,
    CFITG_ST_RUN
  } cfitg_state_e;

  cfitg_state_e state_r, state_nxt;
  logic uniform_r, uniform_nxt;
  logic page512_r, page512_nxt;
  logic ready_nxt;
  logic [DATA_W-1:0] rom_data;

  // Variant straps are caught by a clocked process on the first edge after reset release.
  always_comb begin
    state_nxt = state_r;
    uniform_nxt = uniform_r;
    page512_nxt = page512_r;
    ready_nxt = ready_r;
    case (state_r)
      CFITG_ST_CAPTURE: begin
        // The straps are held for the rest of the run, so a strap that moves later
        // cannot change the table under a host that is part way through reading it.
        uniform_nxt = opt_uniform;
        page512_nxt = opt_page512;
        // Requests are taken from one edge after reset release, once the straps are settled; the first answer comes on the second edge.
        ready_nxt = 1'b1;
        state_nxt = CFITG_ST_RUN;
      end
      CFITG_ST_RUN: begin
        state_nxt = CFITG_ST_RUN;
      end
      default: begin
        state_nxt = CFITG_ST_CAPTURE;
        ready_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= CFITG_ST_CAPTURE;
      uniform_r <= 1'b0;
      page512_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      uniform_r <= uniform_nxt;
      page512_r <= page512_nxt;
      ready_r <= ready_nxt;
    end
  end

  // The table is addressed straight from the read port; its byte is registered below.
  cfitg_rom u_rom (
    .addr(rd_addr),
    .uniform(uniform_r),
    .page512(page512_r),
    .data(rom_data)
  );

  // Read path: one byte per request, answered on the next edge.
  logic rd_valid_nxt;
  logic [DATA_W-1:0] rd_data_nxt;
  logic rd_in_range_nxt;

  always_comb begin
    rd_valid_nxt = 1'b0;
    rd_data_nxt = rd_data_r;
    rd_in_range_nxt = rd_in_range_r;
    if (ready_r && rd_req) begin
      // A held request is answered again on every edge, one byte per cycle.
      rd_valid_nxt = 1'b1;
      rd_data_nxt = rom_data;
      // The range flag tells a reserved FFh apart from a byte outside the table.
      rd_in_range_nxt = (rd_addr >= A_FIRST) && (rd_addr <= A_LAST);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_valid_r <= 1'b0;
      rd_data_r <= 8'h00;
      rd_in_range_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
      rd_in_range_r <= rd_in_range_nxt;
    end
  end

  // Writes have no storage to reach; they are only reported as refused.
  // The data bits are deliberately dropped, since nothing in the table can change.
  logic wr_refused_nxt;
  logic [ADDR_W-1:0] wr_refused_addr_nxt;
  logic wr_data_any;

  always_comb begin
    wr_data_any = |wr_data;
    wr_refused_nxt = 1'b0;
    wr_refused_addr_nxt = wr_refused_addr_r;
    if (ready_r && wr_req) begin
      // Every write is refused, whatever data it carries.
      wr_refused_nxt = 1'b1 | wr_data_any;
      // The address is kept so that a host can see which byte it tried to change.
      wr_refused_addr_nxt = wr_addr;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_refused_r <= 1'b0;
      wr_refused_addr_r <= 8'h00;
    end else begin
      wr_refused_r <= wr_refused_nxt;
      wr_refused_addr_r <= wr_refused_addr_nxt;
    end
  end

  // Sector locator. The query bytes always describe the delivered bottom layout;
  // this path follows the live top-select bit so that erase logic finds the real sector.
  logic loc_valid_nxt;
  logic loc_small_nxt;
  logic [8:0] loc_index_nxt;
  logic [4:0] loc_size_nxt;
  logic [ARR_W-1:0] loc_base_nxt;
  logic small_top_nxt;
  // The number of the 64 KB block that holds the address.
  logic [7:0] blk;
  logic in_small;

  always_comb begin
    blk = loc_addr[23:16];
    // On hybrid parts the flag follows the live bit every cycle, so a configuration change shows one edge later; uniform parts hold it at 0.
    small_top_nxt = small_sector_top_select & ~uniform_r;
    in_small = !uniform_r && (small_sector_top_select ? (blk == TOP_BLOCK) : (blk == 8'h00));
    loc_valid_nxt = 1'b0;
    loc_small_nxt = loc_small_r;
    loc_index_nxt = loc_index_r;
    loc_size_nxt = loc_size_r;
    loc_base_nxt = loc_base_r;
    // Requests before ready_r are dropped with no answer, as on the read and write ports.
    if (ready_r && loc_req) begin
      loc_valid_nxt = 1'b1;
      // Uniform parts ignore the top-select bit, as they have no small sectors to move.
      if (uniform_r) begin
        loc_small_nxt = 1'b0;
        loc_index_nxt = {3'h0, loc_addr[23:18]};
        loc_size_nxt = SZ_BIG;
        loc_base_nxt = {loc_addr[23:18], 18'h00000};
      end else if (in_small) begin
        loc_small_nxt = 1'b1;
        loc_size_nxt = SZ_SMALL;
        loc_base_nxt = {loc_addr[23:12], 12'h000};
        if (small_sector_top_select) begin
          // With the small sectors on top, blocks 00h to FEh are the 255 big sectors
          // numbered 0 to 254, so the first small sector takes number 255.
          loc_index_nxt = {1'b0, TOP_BLOCK} + {5'h00, loc_addr[15:12]};
        end else begin
          loc_index_nxt = {5'h00, loc_addr[15:12]};
        end
      end else begin
        loc_small_nxt = 1'b0;
        loc_size_nxt = SZ_MID;
        loc_base_nxt = {loc_addr[23:16], 16'h0000};
        if (small_sector_top_select) begin
          loc_index_nxt = {1'b0, blk};
        end else begin
          // The sixteen small sectors come first, so block 01h is sector 16.
          loc_index_nxt = 9'({1'b0, blk} + {5'h00, SMALL_CNT} + MID_TOP_OFS - MID_TOP_OFS);
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      loc_valid_r <= 1'b0;
      loc_small_r <= 1'b0;
      loc_index_r <= 9'h000;
      loc_size_r <= 5'h00;
      loc_base_r <= 24'h000000;
      small_top_r <= 1'b0;
    end else begin
      loc_valid_r <= loc_valid_nxt;
      loc_small_r <= loc_small_nxt;
      loc_index_r <= loc_index_nxt;
      loc_size_r <= loc_size_nxt;
      loc_base_r <= loc_base_nxt;
      small_top_r <= small_top_nxt;
    end
  end
endmodule : cfitg_top

// ==== sim/cfitg_sva.sv ====
// Concurrent checks on the table read, write refusal and locator ports.
`timescale 1ns/1ps
module cfitg_sva
  import cfitg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic opt_uniform,
  input wire logic small_sector_top_select,
  input wire logic ready_r,
  input wire logic rd_req,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic wr_req,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic loc_req,
  input wire logic rd_valid_r,
  input wire logic [DATA_W-1:0] rd_data_r,
  input wire logic rd_in_range_r,
  input wire logic wr_refused_r,
  input wire logic [ADDR_W-1:0] wr_refused_addr_r,
  input wire logic loc_valid_r,
  input wire logic small_top_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire rd_go = ready_r && rd_req;
  rd_answer_a: assert property (rd_go |=> rd_valid_r) else $error("read not answered");
  rd_pulse_a: assert property (!rd_go |=> !rd_valid_r) else $error("stray read answer");
  rd_hold_a: assert property (!rd_valid_r |-> $stable(rd_data_r)) else $error("read data moved");
  byte_tmo_a: assert property (rd_go && rd_addr == 8'h1f |=> rd_data_r == 8'h06 && rd_in_range_r)
    else $error("byte timeout wrong");
  chip_tmo_a: assert property (rd_go && rd_addr == 8'h22 |=> rd_data_r == 8'h0f) else $error("chip erase wrong");
  rsvd_ff_a: assert property (rd_go && rd_addr inside {[8'h35:8'h3f]} |=> rd_data_r == 8'hff)
    else $error("reserved byte wrong");
  out_range_a: assert property (rd_go && !(rd_addr inside {[8'h1b:8'h3f]}) |=> !rd_in_range_r)
    else $error("range flag wrong");
  wr_refuse_a: assert property (ready_r && wr_req |=> wr_refused_r && wr_refused_addr_r == $past(wr_addr))
    else $error("write not refused");
  loc_answer_a: assert property (ready_r && loc_req |=> loc_valid_r) else $error("locate not answered");
  top_flag_a: assert property (ready_r && $past(ready_r) |-> small_top_r ==
    ($past(small_sector_top_select) && !opt_uniform)) else $error("top flag wrong");
  rsvd_c: cover property (rd_go && rd_addr == 8'h35);
  wr_c: cover property (ready_r && wr_req);
  top_c: cover property (ready_r && loc_req && small_sector_top_select);
endmodule : cfitg_sva

bind cfitg_top cfitg_sva u_sva (.clk_sys, .rstn, .opt_uniform, .small_sector_top_select, .ready_r, .rd_req,
  .rd_addr, .wr_req, .wr_addr, .loc_req, .rd_valid_r, .rd_data_r, .rd_in_range_r, .wr_refused_r,
  .wr_refused_addr_r, .loc_valid_r, .small_top_r);

// ==== sim/cfitg_host.sv ====
// Behavioural query host that reads table bytes through the read port.
`timescale 1ns/1ps
module cfitg_host
  import cfitg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rd_valid_r,
  input wire logic [DATA_W-1:0] rd_data_r,
  input wire logic rd_in_range_r,
  output logic rd_req,
  output logic [ADDR_W-1:0] rd_addr
);
  initial begin
    rd_req = 1'b0;
    rd_addr = 8'h00;
  end
  // The idle address is the inverse of the last one, so a stale address never looks live.
  task automatic read_byte(input logic [7:0] a, input int gap, output logic [8:0] r);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    #1;
    rd_req = 1'b1;
    rd_addr = a;
    @(posedge clk_sys);
    #1;
    rd_req = 1'b0;
    rd_addr = ~a;
    r = rd_valid_r ? {rd_in_range_r, rd_data_r} : 9'h1xx;
  endtask : read_byte
endmodule : cfitg_host

// ==== sim/testbench.sv ====
// Self-checking bench for the query table, write refusal and sector locator.
`timescale 1ns/1ps
module testbench
  import cfitg_pkg::*;
;
  logic clk_sys = 1'b0, rstn = 1'b0, opt_uniform = 1'b0, opt_page512 = 1'b0, small_sector_top_select = 1'b0;
  logic wr_req = 1'b0, loc_req = 1'b0, rd_req, ready_r, rd_valid_r, rd_in_range_r, wr_refused_r;
  logic loc_valid_r, loc_small_r, small_top_r;
  logic [7:0] rd_addr, wr_addr = 8'h00, wr_data = 8'h00, rd_data_r, wr_refused_addr_r;
  logic [ARR_W-1:0] loc_addr = 24'h000000, loc_base_r;
  logic [8:0] loc_index_r, r;
  logic [4:0] loc_size_r;
  int fails = 0, num_checks = 0;
  always #5 clk_sys = ~clk_sys;
  cfitg_top dut (.clk_sys, .rstn, .opt_uniform, .opt_page512, .small_sector_top_select, .rd_req, .rd_addr,
    .wr_req, .wr_addr, .wr_data, .loc_req, .loc_addr, .ready_r, .rd_valid_r, .rd_data_r, .rd_in_range_r,
    .wr_refused_r, .wr_refused_addr_r, .loc_valid_r, .loc_small_r, .loc_index_r, .loc_size_r, .loc_base_r,
    .small_top_r);
  cfitg_host u_host (.clk_sys, .rd_valid_r, .rd_data_r, .rd_in_range_r, .rd_req, .rd_addr);
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  function automatic logic [7:0] exp_byte(input logic [7:0] a, input logic uni);
    case (a)
      8'h1b: return 8'h27;
      8'h1c: return 8'h36;
      8'h1d, 8'h1e, 8'h2b, 8'h2e: return 8'h00;
      8'h1f: return 8'h06;
      8'h20: return 8'h0a;
      8'h21: return uni ? 8'h0a : 8'h08;
      8'h22: return 8'h0f;
      8'h23, 8'h24, 8'h28: return 8'h02;
      8'h25, 8'h26: return 8'h03;
      8'h27: return 8'h18;
      8'h29: return 8'h01;
      8'h2a: return uni ? 8'h09 : 8'h08;
      8'h2c: return uni ? 8'h01 : 8'h02;
      8'h2d: return uni ? 8'h3f : 8'h0f;
      8'h2f: return uni ? 8'h00 : 8'h10;
      8'h30: return uni ? 8'h04 : 8'h00;
      8'h31: return uni ? 8'hff : 8'hfe;
      8'h32, 8'h33: return uni ? 8'hff : 8'h00;
      8'h34: return uni ? 8'hff : 8'h01;
      default: return 8'hff;
    endcase
  endfunction : exp_byte
  task automatic t_table(input logic uni, input logic p512);
    logic [7:0] a;
    rstn = 1'b0;
    opt_uniform = uni;
    opt_page512 = p512;
    repeat (12) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    check("ready", ready_r, 1'b1);
    // Addresses just outside the table are read too, since the edges are where decoders slip.
    for (int i = 8'h18; i <= 8'h42; i++) begin
      a = i[7:0];
      u_host.read_byte(a, i % 3, r);
      check("table byte", r,
            {a >= 8'h1b && a <= 8'h3f, exp_byte(a, uni)});
    end
    $display("test table done");
  endtask : t_table
  task automatic t_write();
    @(posedge clk_sys);
    #1;
    wr_req = 1'b1;
    wr_addr = 8'h21;
    wr_data = 8'h55;
    @(posedge clk_sys);
    #1;
    check("refused", {wr_refused_r, wr_refused_addr_r}, 9'h121);
    wr_addr = 8'h2a;
    wr_data = 8'h00;
    @(posedge clk_sys);
    #1;
    wr_req = 1'b0;
    wr_addr = 8'hd5;
    wr_data = 8'hff;
    check("refused again", {wr_refused_r, wr_refused_addr_r}, 9'h12a);
    @(posedge clk_sys);
    #1;
    check("refused end", wr_refused_r, 1'b0);
    u_host.read_byte(8'h21, 0, r);
    check("after write", r, 9'h108);
    u_host.read_byte(8'h2a, 0, r);
    check("after write", r, 9'h108);
    $display("test write done");
  endtask : t_write
  task automatic loc(input logic [23:0] a, input logic sm, input logic [8:0] idx, input logic [4:0] sz,
                     input logic [23:0] base);
    @(posedge clk_sys);
    #1;
    loc_req = 1'b1;
    loc_addr = a;
    @(posedge clk_sys);
    #1;
    loc_req = 1'b0;
    loc_addr = ~a;
    check("locate", {loc_valid_r, loc_small_r, loc_index_r, loc_size_r, loc_base_r},
          {1'b1, sm, idx, sz, base});
  endtask : loc
  task automatic t_locate();
    loc(24'h003456, 1'b1, 9'h003, 5'h0c, 24'h003000);
    loc(24'h00ffff, 1'b1, 9'h00f, 5'h0c, 24'h00f000);
    loc(24'h012345, 1'b0, 9'h010, 5'h10, 24'h010000);
    loc(24'hffffff, 1'b0, 9'h10e, 5'h10, 24'hff0000);
    small_sector_top_select = 1'b1;
    @(posedge clk_sys);
    #1;
    check("top flag", small_top_r, 1'b1);
    loc(24'h003456, 1'b0, 9'h000, 5'h10, 24'h000000);
    loc(24'hfeffff, 1'b0, 9'h0fe, 5'h10, 24'hfe0000);
    loc(24'hff1234, 1'b1, 9'h100, 5'h0c, 24'hff1000);
    u_host.read_byte(8'h2d, 1, r);
    check("geometry kept", r, 9'h10f);
    small_sector_top_select = 1'b0;
    $display("test locate done");
  endtask : t_locate
  task automatic t_uniform();
    loc(24'h012345, 1'b0, 9'h000, 5'h12, 24'h000000);
    loc(24'hfc0000, 1'b0, 9'h03f, 5'h12, 24'hfc0000);
    small_sector_top_select = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    check("uniform top flag", small_top_r, 1'b0);
    $display("test uniform done");
  endtask : t_uniform
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  initial begin
    #100000;
    fails++;
    results();
  end
  initial begin
    t_table(1'b0, 1'b0);
    t_write();
    t_locate();
    t_table(1'b0, 1'b1);
    t_table(1'b1, 1'b1);
    t_uniform();
    results();
  end
endmodule : testbench
